//--- hw/wdt_cnt_if.sv
// carrier between the watchdog control logic and its counter
`timescale 1ns/100ps
`default_nettype none
interface wdt_cnt_if;
   logic       restart;
   logic       reset_en;
   logic [1:0] sel;
   logic       timeout;
   logic       wdog_rst;

   modport ctl
   (
      output restart,
      output reset_en,
      output sel,
      input  timeout,
      input  wdog_rst
   );
   modport cnt
   (
      input  restart,
      input  reset_en,
      input  sel,
      output timeout,
      output wdog_rst
   );
endinterface
`default_nettype wire

//--- hw/wdt_counter.sv
// watchdog interval counter and post-timeout reset delay
`timescale 1ns/100ps
`default_nettype none
module wdt_counter
#(
   parameter int CNT_W = 27,
   parameter int INT0  = 131072,
   parameter int INT1  = 1048576,
   parameter int INT2  = 8388608,
   parameter int INT3  = 67108864
)
(
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst_b,
   input  wire logic ce,
   // control side
   wdt_cnt_if.cnt    cif
);
   logic [CNT_W-1:0]          cnt_reg;
   logic [CNT_W-1:0]          term;
   logic [wdt_pkg::DLY_W-1:0] dly_reg;
   logic                      dly_run_reg;
   logic                      at_term;
   logic                      fire;

   // -------------------------------------------------------------
   // terminal count
   // -------------------------------------------------------------
   always_comb
   begin
      unique case (cif.sel)
         wdt_pkg::SEL_INT0: term = CNT_W'(INT0 - 1);
         wdt_pkg::SEL_INT1: term = CNT_W'(INT1 - 1);
         wdt_pkg::SEL_INT2: term = CNT_W'(INT2 - 1);
         wdt_pkg::SEL_INT3: term = CNT_W'(INT3 - 1);
      endcase
   end

   assign at_term = (cnt_reg >= term);
   assign fire    = dly_run_reg && (dly_reg == wdt_pkg::DLY_FIRE) && cif.reset_en;

   // -------------------------------------------------------------
   // interval count, one step per clock with the enable high
   // -------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         cnt_reg <= '0;
      else if (ce)
      begin
         if (cif.restart || cif.wdog_rst)
            cnt_reg <= '0;
         else if (at_term)
            cnt_reg <= '0;
         else
            cnt_reg <= cnt_reg + CNT_W'(1);
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         cif.timeout <= 1'b0;
      else if (ce)
         cif.timeout <= at_term && !cif.restart && !cif.wdog_rst;
   end

   // -------------------------------------------------------------
   // reset delay after the flag is raised
   // -------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dly_reg     <= '0;
         dly_run_reg <= 1'b0;
      end
      else if (ce)
      begin
         if (cif.restart || cif.wdog_rst)
            dly_run_reg <= 1'b0;
         else if (cif.timeout)
         begin
            dly_run_reg <= 1'b1;
            dly_reg     <= '0;
         end
         else if (dly_run_reg)
         begin
            dly_reg <= dly_reg + wdt_pkg::DLY_W'(1);
            if (dly_reg == wdt_pkg::DLY_FIRE)
               dly_run_reg <= 1'b0;
         end
      end
   end

   // reset fires only with reset enabled at the end of the delay
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         cif.wdog_rst <= 1'b0;
      else if (ce)
         cif.wdog_rst <= fire && !cif.restart;
   end
endmodule
`default_nettype wire

//--- hw/wdt_pkg.sv
// constants and types shared by the watchdog with timed-access protection
package wdt_pkg;
   // -------------------------------------------------------------
   // register addresses on the special function register bus
   // -------------------------------------------------------------
   localparam logic [7:0] ADDR_CLK_INTERVAL_CTRL = 8'h8e;
   localparam logic [7:0] ADDR_TIMED_ACCESS_KEY  = 8'hc7;
   localparam logic [7:0] ADDR_WATCHDOG_CONTROL  = 8'hd8;

   // -------------------------------------------------------------
   // reset values and unlock keys
   // -------------------------------------------------------------
   localparam logic [7:0] CLK_INTERVAL_CTRL_RST = 8'h03;
   localparam logic [7:0] WATCHDOG_CONTROL_RST  = 8'h00;
   localparam logic [7:0] KEY_FIRST             = 8'haa;
   localparam logic [7:0] KEY_SECOND            = 8'h55;
   localparam logic [3:0] WDCTL_UNUSED_READ     = 4'h0;

   // -------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------
   localparam int BIT_IRQ_FLAG    = 3;
   localparam int BIT_RESET_CAUSE = 2;
   localparam int BIT_RESET_EN    = 1;
   localparam int BIT_RESTART     = 0;
   localparam int SEL_HI          = 7;
   localparam int SEL_LO          = 6;

   // -------------------------------------------------------------
   // timing counts
   // -------------------------------------------------------------
   localparam int            DLY_W          = 10;
   localparam logic [DLY_W-1:0] RST_DELAY_CLKS = 10'h200;
   localparam logic [DLY_W-1:0] DLY_FIRE       = RST_DELAY_CLKS - 10'h002;
   localparam logic [1:0]    UNLOCK_INSTRS  = 2'h3;
   localparam logic [1:0]    SEL_INT0       = 2'h0;
   localparam logic [1:0]    SEL_INT1       = 2'h1;
   localparam logic [1:0]    SEL_INT2       = 2'h2;
   localparam logic [1:0]    SEL_INT3       = 2'h3;

   // unlock sequencer
   typedef enum logic [1:0]
   {
      TA_IDLE   = 2'b00,
      TA_GOT_AA = 2'b01,
      TA_OPEN   = 2'b10
   } wdt_ta_state_type;
endpackage

//--- hw/wdt_timed_access.sv
// watchdog timer with timed-access protected control register
`timescale 1ns/100ps
`default_nettype none
module wdt_timed_access
#(
   parameter int CNT_W = 27,
   parameter int INT0  = 131072,
   parameter int INT1  = 1048576,
   parameter int INT2  = 8388608,
   parameter int INT3  = 67108864
)
(
   // clock, reset, enable
   input  wire logic       mclk,
   input  wire logic       rst_b,
   input  wire logic       ce,
   // special function register bus
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_direct,
   input  wire logic [7:0] sfr_wdata,
   input  wire logic       sfr_rd,
   output logic      [7:0] sfr_rdata,
   // instruction boundary strobe from the core
   input  wire logic       instr_end,
   // enables held by the interrupt controller
   input  wire logic       wdog_irq_enable,
   input  wire logic       global_irq_enable,
   // events
   output logic            wdog_irq_req,
   output logic            wdog_reset_out
);
   wdt_cnt_if cif();

   logic [7:0]                clock_and_interval_control_reg;
   logic                      wdog_irq_flag_reg;
   logic                      wdog_reset_cause_flag_reg;
   logic                      wdog_reset_enable_reg;
   logic                      wdog_restart_reg;
   wdt_pkg::wdt_ta_state_type ta_state_reg;
   logic [1:0]                ta_instr_reg;
   logic                      wr_key;
   logic                      wr_wdctl;
   logic                      wr_clock_and_interval_control;
   logic                      wdctl_ok;
   logic [7:0]                wdctl_view;

   // -------------------------------------------------------------
   // write decode
   // -------------------------------------------------------------
   assign wr_key   = ce && sfr_wr && (sfr_addr == wdt_pkg::ADDR_TIMED_ACCESS_KEY);
   assign wr_wdctl = ce && sfr_wr && (sfr_addr == wdt_pkg::ADDR_WATCHDOG_CONTROL);
   assign wr_clock_and_interval_control = ce && sfr_wr && (sfr_addr == wdt_pkg::ADDR_CLK_INTERVAL_CTRL);
   // only a direct write inside an open window reaches the register
   assign wdctl_ok = wr_wdctl && sfr_direct && (ta_state_reg == wdt_pkg::TA_OPEN);

   // -------------------------------------------------------------
   // timed-access unlock sequencer
   // -------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ta_state_reg <= wdt_pkg::TA_IDLE;
         ta_instr_reg <= 2'h0;
      end
      else if (ce)
      begin
         unique case (ta_state_reg)
            wdt_pkg::TA_IDLE:
            begin
               ta_instr_reg <= 2'h0;
               if (wr_key && (sfr_wdata == wdt_pkg::KEY_FIRST))
                  ta_state_reg <= wdt_pkg::TA_GOT_AA;
            end
            wdt_pkg::TA_GOT_AA:
            begin
               if (sfr_wr)
               begin
                  ta_instr_reg <= 2'h0;
                  if (wr_key && (sfr_wdata == wdt_pkg::KEY_SECOND))
                     ta_state_reg <= wdt_pkg::TA_OPEN;
                  else
                     ta_state_reg <= wdt_pkg::TA_IDLE;
               end
               else if (instr_end)
               begin
                  ta_instr_reg <= ta_instr_reg + 2'h1;
                  if (ta_instr_reg == wdt_pkg::UNLOCK_INSTRS - 2'h1)
                     ta_state_reg <= wdt_pkg::TA_IDLE;
               end
            end
            wdt_pkg::TA_OPEN:
            begin
               // any write, allowed or not, uses up the window
               if (sfr_wr)
                  ta_state_reg <= wdt_pkg::TA_IDLE;
               else if (instr_end)
               begin
                  ta_instr_reg <= ta_instr_reg + 2'h1;
                  if (ta_instr_reg == wdt_pkg::UNLOCK_INSTRS - 2'h1)
                     ta_state_reg <= wdt_pkg::TA_IDLE;
               end
            end
            default:
               ta_state_reg <= wdt_pkg::TA_IDLE;
         endcase
      end
   end

   // -------------------------------------------------------------
   // clock and interval control, unprotected
   // -------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         clock_and_interval_control_reg <= wdt_pkg::CLK_INTERVAL_CTRL_RST;
      else if (wr_clock_and_interval_control)
         clock_and_interval_control_reg <= sfr_wdata;
   end

   // -------------------------------------------------------------
   // watchdog control bits
   // -------------------------------------------------------------
   // hardware set wins over a software clear in the same cycle
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         wdog_irq_flag_reg <= wdt_pkg::WATCHDOG_CONTROL_RST[wdt_pkg::BIT_IRQ_FLAG];
      else if (ce)
      begin
         if (cif.timeout)
            wdog_irq_flag_reg <= 1'b1;
         else if (wdctl_ok)
            wdog_irq_flag_reg <= sfr_wdata[wdt_pkg::BIT_IRQ_FLAG];
      end
   end

   // the reset pin of this block is the system reset, not the watchdog's own
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         wdog_reset_cause_flag_reg <= wdt_pkg::WATCHDOG_CONTROL_RST[wdt_pkg::BIT_RESET_CAUSE];
      else if (ce)
      begin
         if (cif.wdog_rst)
            wdog_reset_cause_flag_reg <= 1'b1;
         else if (wdctl_ok)
            wdog_reset_cause_flag_reg <= sfr_wdata[wdt_pkg::BIT_RESET_CAUSE];
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         wdog_reset_enable_reg <= wdt_pkg::WATCHDOG_CONTROL_RST[wdt_pkg::BIT_RESET_EN];
      else if (wdctl_ok)
         wdog_reset_enable_reg <= sfr_wdata[wdt_pkg::BIT_RESET_EN];
   end

   // one-shot restart strobe
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         wdog_restart_reg <= wdt_pkg::WATCHDOG_CONTROL_RST[wdt_pkg::BIT_RESTART];
      else if (ce)
         wdog_restart_reg <= wdctl_ok && sfr_wdata[wdt_pkg::BIT_RESTART];
   end

   // -------------------------------------------------------------
   // counter
   // -------------------------------------------------------------
   assign cif.restart  = wdog_restart_reg;
   assign cif.reset_en = wdog_reset_enable_reg;
   assign cif.sel      = clock_and_interval_control_reg[wdt_pkg::SEL_HI:wdt_pkg::SEL_LO];

   wdt_counter
   #(
      .CNT_W (CNT_W),
      .INT0  (INT0),
      .INT1  (INT1),
      .INT2  (INT2),
      .INT3  (INT3)
   )
   u_counter
   (
      .mclk  (mclk),
      .rst_b (rst_b),
      .ce    (ce),
      .cif   (cif)
   );

   // -------------------------------------------------------------
   // event outputs
   // -------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wdog_irq_req   <= 1'b0;
         wdog_reset_out <= 1'b0;
      end
      else if (ce)
      begin
         wdog_irq_req   <= wdog_irq_flag_reg && wdog_irq_enable && global_irq_enable;
         wdog_reset_out <= cif.wdog_rst;
      end
   end

   // -------------------------------------------------------------
   // read port, one cycle latency
   // -------------------------------------------------------------
   assign wdctl_view = {wdt_pkg::WDCTL_UNUSED_READ,
                        wdog_irq_flag_reg,
                        wdog_reset_cause_flag_reg,
                        wdog_reset_enable_reg,
                        wdog_restart_reg};

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         sfr_rdata <= 8'h00;
      else if (ce && sfr_rd)
      begin
         unique case (sfr_addr)
            wdt_pkg::ADDR_WATCHDOG_CONTROL:  sfr_rdata <= wdctl_view;
            wdt_pkg::ADDR_CLK_INTERVAL_CTRL: sfr_rdata <= clock_and_interval_control_reg;
            default:                         sfr_rdata <= 8'h00;
         endcase
      end
   end
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// self-checking bench for the timed-access watchdog
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin err_total++; \
   $display("BAD %s exp %h got %h", nm, e, a); end end
module tb_top;
   // shortened intervals keep the run brief, all above the 512 delay
   localparam int I0 = 1024;
   localparam int I1 = 2048;
   localparam int I2 = 4096;
   localparam int I3 = 8192;
   logic       mclk, rst_b, ce, sfr_wr, sfr_direct, sfr_rd, instr_end;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
   logic       wdog_irq_enable, global_irq_enable, wdog_irq_req, wdog_reset_out;
   int         err_total, n_checks, cyc, rst_seen, k;
   int         iv [4] = '{I0, I1, I2, I3};

   wdt_timed_access #(.INT0(I0), .INT1(I1), .INT2(I2), .INT3(I3)) u_wdt_timed_access
   (
      .mclk(mclk), .rst_b(rst_b), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_direct(sfr_direct), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
      .instr_end(instr_end), .wdog_irq_enable(wdog_irq_enable),
      .global_irq_enable(global_irq_enable), .wdog_irq_req(wdog_irq_req),
      .wdog_reset_out(wdog_reset_out)
   );

   always #50 mclk = ~mclk;

   // cycle ceiling and reset-pulse tally
   always @(posedge mclk)
   begin
      cyc++;
      if (wdog_reset_out === 1'b1)
         rst_seen++;
      if (cyc == 40000)
      begin
         err_total++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // -------------------------------------------------------------
   // bus helpers
   // -------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic dir);
      @(negedge mclk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_direct = dir;
      sfr_wr = 1'b1;
      @(negedge mclk);
      sfr_wr = 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
      @(negedge mclk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge mclk);
      sfr_rd = 1'b0;
      @(negedge mclk);
      `CHK(nm, e, sfr_rdata)
   endtask

   task automatic unlock(input logic [7:0] d);
      wr(8'hc7, 8'haa, 1'b1);
      wr(8'hc7, 8'h55, 1'b1);
      wr(8'hd8, d, 1'b1);
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask

   // bounded wait on the request (0) or the reset pulse (1)
   task automatic wait_on(input bit which, input int lim);
      k = 0;
      while ((which ? wdog_reset_out : wdog_irq_req) !== 1'b1 && k < lim)
      begin
         @(negedge mclk);
         k++;
      end
   endtask

   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task automatic t_locked();
      wr(8'hd8, 8'h02, 1'b1);
      rd_chk(8'hd8, 8'h00, "plain write");
      wr(8'hc7, 8'haa, 1'b1);
      wr(8'h8e, 8'h03, 1'b1);
      wr(8'hc7, 8'h55, 1'b1);
      wr(8'hd8, 8'h02, 1'b1);
      rd_chk(8'hd8, 8'h00, "broken order");
      wr(8'hc7, 8'haa, 1'b1);
      wr(8'hc7, 8'h55, 1'b1);
      wr(8'hd8, 8'h02, 1'b0);
      rd_chk(8'hd8, 8'h00, "indirect");
      wr(8'hc7, 8'haa, 1'b1);
      wr(8'hc7, 8'h55, 1'b1);
      repeat (3)
      begin
         @(negedge mclk);
         instr_end = 1'b1;
         @(negedge mclk);
         instr_end = 1'b0;
      end
      wr(8'hd8, 8'h02, 1'b1);
      rd_chk(8'hd8, 8'h00, "lapsed");
   endtask

   task automatic t_timeout();
      unlock(8'h01);
      rd_chk(8'hd8, 8'h00, "restart clears");
      tick(I0 - 40);
      rd_chk(8'hd8, 8'h00, "early flag");
      // a low enable must hold the count, so expiry slips by the frozen cycles
      ce = 1'b0;
      tick(100);
      ce = 1'b1;
      rd_chk(8'hd8, 8'h00, "frozen count");
      tick(40);
      rd_chk(8'hd8, 8'h08, "flag");
      `CHK("irq masked", 1'b0, wdog_irq_req)
      wdog_irq_enable = 1'b1;
      global_irq_enable = 1'b1;
      tick(2);
      `CHK("irq on", 1'b1, wdog_irq_req)
      global_irq_enable = 1'b0;
      tick(2);
      `CHK("irq global off", 1'b0, wdog_irq_req)
      tick(600);
      rd_chk(8'hd8, 8'h08, "no cause");
      `CHK("no reset", 0, rst_seen)
   endtask

   task automatic t_reset_path();
      unlock(8'h03);
      rd_chk(8'hd8, 8'h02, "armed");
      global_irq_enable = 1'b1;
      wait_on(1'b0, I0 + 100);
      `CHK("timeout irq", 1'b1, wdog_irq_req)
      wait_on(1'b1, 700);
      `CHK("reset delay", 511, k)
      rd_chk(8'hd8, 8'h0e, "cause");
      unlock(8'h02);
      rd_chk(8'hd8, 8'h02, "sw clear");
      wait_on(1'b0, I0 + 100);
      `CHK("still running", 1'b1, wdog_irq_req)
      unlock(8'h03);
      tick(600);
      `CHK("restart cancels", 1, rst_seen)
   endtask

   task automatic t_sw_set();
      // reset stays enabled so a software-set cause flag would show if it fired
      unlock(8'h0f);
      tick(3);
      `CHK("sw flag irq", 1'b1, wdog_irq_req)
      tick(600);
      `CHK("sw cause no reset", 1, rst_seen)
      rd_chk(8'hd8, 8'h0e, "cause holds");
      rst_b = 1'b0;
      tick(2);
      rst_b = 1'b1;
      rd_chk(8'hd8, 8'h00, "reset clears");
      wdog_irq_enable = 1'b0;
   endtask

   task automatic t_intervals();
      for (int s = 1; s < 4; s++)
      begin
         wr(8'h8e, {2'(s), 6'h03}, 1'b1);
         rd_chk(8'h8e, {2'(s), 6'h03}, "interval reg");
         unlock(8'h01);
         tick(iv[s] - 40);
         rd_chk(8'hd8, 8'h00, "early");
         tick(40);
         rd_chk(8'hd8, 8'h08, "expired");
      end
   endtask

   initial
   begin
      {mclk, rst_b, sfr_wr, sfr_direct, sfr_rd, instr_end} = 6'h00;
      {sfr_addr, sfr_wdata, wdog_irq_enable, global_irq_enable} = 18'h0;
      ce = 1'b1;
      repeat (20) @(negedge mclk);
      rst_b = 1'b1;
      rd_chk(8'h8e, 8'h03, "interval reset");
      rd_chk(8'hd8, 8'h00, "control reset");
      rd_chk(8'hc7, 8'h00, "key read");
      rd_chk(8'h10, 8'h00, "unmapped");
      t_locked();
      t_timeout();
      t_reset_path();
      t_sw_set();
      t_intervals();
      give_verdict();
   end
endmodule

bind wdt_timed_access wdt_monitor #(.INT0(INT0)) u_wdt_monitor
(
   .mclk(mclk), .rst_b(rst_b), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
   .sfr_direct(sfr_direct), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
   .instr_end(instr_end), .wdog_irq_enable(wdog_irq_enable),
   .global_irq_enable(global_irq_enable), .wdog_irq_req(wdog_irq_req),
   .wdog_reset_out(wdog_reset_out)
);
`default_nettype wire

//--- testbench/wdt_monitor.sv
// port-level assertions for the timed-access watchdog
`timescale 1ns/100ps
`default_nettype none
module wdt_monitor
#(
   parameter int INT0 = 131072
)
(
   // clock and reset
   input wire logic       mclk,
   input wire logic       rst_b,
   input wire logic       ce,
   // register bus
   input wire logic [7:0] sfr_addr,
   input wire logic       sfr_wr,
   input wire logic       sfr_direct,
   input wire logic [7:0] sfr_wdata,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_rdata,
   // core strobe and enables
   input wire logic       instr_end,
   input wire logic       wdog_irq_enable,
   input wire logic       global_irq_enable,
   // events
   input wire logic       wdog_irq_req,
   input wire logic       wdog_reset_out
);
   logic [31:0] gap_reg;
   logic        rd_go;
   logic        rd_known;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   assign rd_go    = sfr_rd && ce;
   assign rd_known = sfr_addr inside {8'h8e, 8'hc7, 8'hd8};

   // cycles since reset or the last watchdog reset pulse
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         gap_reg <= 32'h0;
      else if (wdog_reset_out)
         gap_reg <= 32'h0;
      else
         gap_reg <= gap_reg + 32'h1;
   end

   // -------------------------------------------------------------
   // properties
   // -------------------------------------------------------------
   property p_irq_gate; wdog_irq_req |-> $past(wdog_irq_enable) && $past(global_irq_enable); endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without enables");
   property p_irq_fall; $fell(wdog_irq_req) |-> !$past(wdog_irq_enable) ||
      !$past(global_irq_enable) || $past(sfr_wr) || $past(sfr_wr, 2); endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq dropped by itself");
   property p_rst_pulse; wdog_reset_out |=> !wdog_reset_out; endproperty
   a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
   property p_rst_gap; wdog_reset_out |-> gap_reg >= INT0 + 500; endproperty
   a_rst_gap: assert property (p_rst_gap) else $error("reset too early");
   property p_rd_key; rd_go && sfr_addr == 8'hc7 |=> sfr_rdata == 8'h00; endproperty
   a_rd_key: assert property (p_rd_key) else $error("key register readable");
   property p_rd_gap; rd_go && !rd_known |=> sfr_rdata == 8'h00; endproperty
   a_rd_gap: assert property (p_rd_gap) else $error("unmapped read not zero");
   property p_rd_hi; rd_go && sfr_addr == 8'hd8 |=> sfr_rdata[7:4] == 4'h0; endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("control high bits set");
   property p_rd_hold; !rd_go |=> $stable(sfr_rdata); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");

   c_reset: cover property (wdog_reset_out);
   c_irq: cover property ($rose(wdog_irq_req));
   c_rd_ctl: cover property (rd_go && sfr_addr == 8'hd8);
endmodule
`default_nettype wire
